// File: logic/tmr_timer16.sv
// 16-bit timer with shared prescaler sync control, two compare channels and one capture channel.
`timescale 1ns/1ps
`include "tmr_defines.svh"

// Functional notes
// [RULE1] Hold mode keeps written prescaler reset bits asserted.
// [RULE2] Clearing hold mode clears both prescaler reset bits.
// [RULE3] Sync reset bit resets the shared prescaler.
// [RULE4] Sync reset self-clears unless hold mode set.
// [RULE5] Count, compare, capture 16 bits; controls 8.
// [RULE6] Four flags, each maskable in mask register.
// [RULE7] Tick from prescaler or pin; off stops counter.
// [RULE8] Compare match sets flag and drives output.
// [RULE9] Capture latches count on edge, optional filter.
// [RULE10] Compare A as PWM TOP drives no output.
// [RULE11] BOTTOM is 0x0000, MAX is 0xFFFF.
// [RULE12] TOP fixed, compare A or capture by mode.
// [RULE13] One shared high-byte holding register.
// [RULE14] Low-byte write loads holding byte plus data.
// [RULE15] Low-byte read copies high byte to holding.
// [RULE16] Compare reads bypass the holding register.
// [RULE17] CPU writes high first, reads low first.
// [RULE18] Power-off bit high keeps the timer disabled.
// [RULE19] External tick per rising or falling edge.
// [RULE20] Internal taps: 1, 8, 64, 256, 1024.
// [RULE21] Held sync reset reads one, prescaler stays zero.
module tmr_timer16
  import tmr_pkg::*;
(
  input  wire logic       i_clock,              // System clock, 200 MHz.
  input  wire logic       i_sys_rst,            // Asynchronous reset, active high.
  input  wire logic [7:0] i_addr,               // Register offset.
  input  wire logic       i_wr,                 // Write strobe, one cycle.
  input  wire logic       i_rd,                 // Read strobe, one cycle.
  input  wire logic [7:0] i_wdata,              // Write data.
  output logic      [7:0] o_rdata,              // Read data, valid the cycle after i_rd.
  input  wire logic       i_timer_power_off,    // Power reduction bit, high disables.
  input  wire logic       i_capture_from_cmp,   // High selects the analog comparator as capture source.
  input  wire logic       i_external_count_pin, // External count pin, asynchronous.
  input  wire logic       i_capture_pin,        // Capture pin, asynchronous.
  input  wire logic       i_analog_cmp,         // Analog comparator output, asynchronous.
  output logic            o_compare_a_output,   // Compare A waveform pin.
  output logic            o_compare_b_output,   // Compare B waveform pin.
  output logic      [3:0] o_irq_req             // Flag AND mask: overflow, A, B, capture.
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic        sync_hold_mode;        // Holds prescaler reset bits.
  logic        sync_prescaler_reset;  // Shared prescaler reset.
  logic        async_prescaler_reset; // Stored only; its prescaler lives elsewhere.
  logic [7:0]  control_a;             // Output modes and low mode bits.
  logic [7:0]  control_b;             // Filter, edge, high mode bits, clock select.
  tmr_word_t   counter_value;         // The counter.
  tmr_word_t   compare_a_value;       // Compare A buffer written by the CPU.
  tmr_word_t   compare_b_value;       // Compare B buffer written by the CPU.
  tmr_word_t   compare_a_active;      // Compare A value in use.
  tmr_word_t   compare_b_active;      // Compare B value in use.
  tmr_word_t   capture_value;         // Capture register.
  logic [7:0]  high_hold;             // Shared high-byte holding register.
  logic [7:0]  irq_flags;             // Sticky event flags.
  logic [7:0]  irq_mask;              // Interrupt mask.
  logic [9:0]  prescaler;             // Free-running shared prescaler.
  logic [3:0]  filter_shift;          // Noise filter sample history.
  logic        filter_level;          // Filtered capture level.
  logic        capture_prev;          // Previous capture level for edges.

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire wr_sync  = i_wr && (i_addr == `TMR_ADR_SYNC);
  wire wr_ca    = i_wr && (i_addr == `TMR_ADR_CTRL_A);
  wire wr_cb    = i_wr && (i_addr == `TMR_ADR_CTRL_B);
  wire wr_cnt_l = i_wr && (i_addr == `TMR_ADR_CNT_L);
  wire wr_cmpa  = i_wr && (i_addr == `TMR_ADR_CMPA_L);
  wire wr_cmpb  = i_wr && (i_addr == `TMR_ADR_CMPB_L);
  wire wr_cap_l = i_wr && (i_addr == `TMR_ADR_CAP_L);
  wire wr_flags = i_wr && (i_addr == `TMR_ADR_FLAGS);
  wire wr_mask  = i_wr && (i_addr == `TMR_ADR_MASK);
  wire wr_high  = i_wr && ((i_addr == `TMR_ADR_CNT_H) || (i_addr == `TMR_ADR_CMPA_H) ||
                           (i_addr == `TMR_ADR_CMPB_H) || (i_addr == `TMR_ADR_CAP_H));
  wire rd_cnt_l = i_rd && (i_addr == `TMR_ADR_CNT_L);
  wire rd_cap_l = i_rd && (i_addr == `TMR_ADR_CAP_L);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire [3:0]   mode        = {control_b[4:3], control_a[1:0]};
  wire tmr_cs_e clock_select = tmr_cs_e'(control_b[2:0]);
  wire         non_pwm     = (mode == 4'h0) || (mode == 4'h4) || (mode == 4'hC) || (mode == 4'hD);
  tmr_top_e    top_sel;
  tmr_word_t   top_value;

  // Each mode picks where TOP comes from; unused codes count up to MAX.
  always_comb
  begin
    unique case (mode)
      4'h1, 4'h5:             top_sel = TMR_TOP_FF;   // RULE12
      4'h2, 4'h6:             top_sel = TMR_TOP_1FF;
      4'h3, 4'h7:             top_sel = TMR_TOP_3FF;
      4'h4, 4'h9, 4'hB, 4'hF: top_sel = TMR_TOP_CMPA;
      4'h8, 4'hA, 4'hC, 4'hE: top_sel = TMR_TOP_CAP;
      default:                top_sel = TMR_TOP_MAX;
    endcase
  end

  // The compare A TOP comes from the active copy, so a run-time change waits for TOP in the PWM modes but applies the next cycle in mode 4.
  always_comb
  begin
    unique case (top_sel)
      TMR_TOP_FF:   top_value = `TMR_TOP_8BIT;    // [RULE12]
      TMR_TOP_1FF:  top_value = `TMR_TOP_9BIT;
      TMR_TOP_3FF:  top_value = `TMR_TOP_10BIT;
      TMR_TOP_CMPA: top_value = compare_a_active; // [RULE10]
      TMR_TOP_CAP:  top_value = capture_value;
      default:      top_value = `TMR_MAX;         // [RULE11]
    endcase
  end

  // ----------------------------------------------------------------
  // Timer tick selection
  // ----------------------------------------------------------------
  logic ext_rise;
  logic ext_fall;

  tmr_edge_sync u_ext_sync
  (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_external_count_pin),
    .o_level   (),
    .o_rise    (ext_rise),
    .o_fall    (ext_fall)
  );

  // A tap fires once every N system clocks because it needs all low prescaler bits set.
  wire tap_8    = &prescaler[2:0];  // [RULE20]
  wire tap_64   = &prescaler[5:0];
  wire tap_256  = &prescaler[7:0];
  wire tap_1024 = &prescaler[9:0];
  wire raw_tick = (clock_select == TMR_CS_DIV1)   ? 1'b1 :
                  (clock_select == TMR_CS_DIV8)   ? tap_8 :
                  (clock_select == TMR_CS_DIV64)  ? tap_64 :
                  (clock_select == TMR_CS_DIV256) ? tap_256 :
                  (clock_select == TMR_CS_DIV1K)  ? tap_1024 :
                  (clock_select == TMR_CS_FALL)   ? ext_fall :  // [RULE19]
                  (clock_select == TMR_CS_RISE)   ? ext_rise : 1'b0;  // [RULE7]
  // A held prescaler stops the prescaled taps, which is how synchronised timers stay halted.
  wire timer_tick = raw_tick && !i_timer_power_off && !(sync_prescaler_reset && clock_select != TMR_CS_DIV1 &&
                    clock_select != TMR_CS_FALL && clock_select != TMR_CS_RISE);  // [RULE18]

  // ----------------------------------------------------------------
  // Sync control and shared prescaler
  // ----------------------------------------------------------------
  // A write that sets the reset bit wins over the self-clear in the same cycle.
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      sync_hold_mode        <= 1'b0;
      sync_prescaler_reset  <= 1'b0;
      async_prescaler_reset <= 1'b0;
    end
    else if (wr_sync)
    begin
      sync_hold_mode        <= i_wdata[`TMR_SYNC_HOLD];  // [RULE1]
      sync_prescaler_reset  <= i_wdata[`TMR_SYNC_SRST];                           // [RULE3]
      async_prescaler_reset <= i_wdata[`TMR_SYNC_ARST] & i_wdata[`TMR_SYNC_HOLD];  // [RULE2]
    end
    else if (!sync_hold_mode)
    begin
      sync_prescaler_reset  <= 1'b0;  // [RULE4]
      async_prescaler_reset <= 1'b0;
    end
  end

  // While the reset bit is held the prescaler sits at zero, so all taps restart together.
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      prescaler <= 10'h000;
    else if (sync_prescaler_reset)
      prescaler <= 10'h000;  // [RULE21]
    else
      prescaler <= prescaler + 10'h001;
  end

  // ----------------------------------------------------------------
  // Counter and compare units
  // ----------------------------------------------------------------
  wire at_top     = (counter_value == top_value);
  wire match_a    = timer_tick && (counter_value == compare_a_active);  // [RULE8]
  wire match_b    = timer_tick && (counter_value == compare_b_active);
  wire overflow   = timer_tick && at_top;
  wire load_cmp   = non_pwm || overflow;  // PWM modes update compare values only at TOP.
  wire a_no_pwm   = !non_pwm && (top_sel == TMR_TOP_CMPA);  // [RULE10]

  // A CPU write to the counter overrides counting in the same cycle.
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      counter_value <= `TMR_RST_WORD;
    else if (wr_cnt_l)
      counter_value <= {high_hold, i_wdata};  // [RULE14]
    else if (overflow)
      counter_value <= `TMR_BOTTOM;           // [RULE11]
    else if (timer_tick)
      counter_value <= counter_value + 16'h0001;
  end

  // Compare buffers take CPU writes; active copies follow them at the mode's update point.
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      compare_a_value  <= `TMR_RST_WORD;
      compare_b_value  <= `TMR_RST_WORD;
      compare_a_active <= `TMR_RST_WORD;
      compare_b_active <= `TMR_RST_WORD;
    end
    else
    begin
      if (wr_cmpa)
        compare_a_value <= {high_hold, i_wdata};  // [RULE14]
      if (wr_cmpb)
        compare_b_value <= {high_hold, i_wdata};
      if (load_cmp)
      begin
        compare_a_active <= compare_a_value;  // [RULE8]
        compare_b_active <= compare_b_value;
      end
    end
  end

  // Match actions per output mode: 01 toggle, 10 clear, 11 set.
  wire next_out_a = (control_a[7:6] == 2'b01) ? ~o_compare_a_output : control_a[6];
  wire next_out_b = (control_a[5:4] == 2'b01) ? ~o_compare_b_output : control_a[4];

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_compare_a_output <= 1'b0;
      o_compare_b_output <= 1'b0;
    end
    else
    begin
      if (a_no_pwm)
        o_compare_a_output <= 1'b0;  // [RULE10]
      else if (match_a && control_a[7:6] != 2'b00)
        o_compare_a_output <= next_out_a;  // [RULE8]
      if (match_b && control_a[5:4] != 2'b00)
        o_compare_b_output <= next_out_b;
    end
  end

  // ----------------------------------------------------------------
  // Capture unit
  // ----------------------------------------------------------------
  logic cap_sync;

  tmr_edge_sync u_cap_sync
  (
    .i_clock   (i_clock),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_capture_from_cmp ? i_analog_cmp : i_capture_pin),
    .o_level   (cap_sync),
    .o_rise    (),
    .o_fall    ()
  );

  // The filter adds five cycles of delay in exchange for rejecting short spikes.
  wire cap_level = control_b[`TMR_CB_NOISE] ? filter_level : cap_sync;
  wire cap_event = (cap_level != capture_prev) && (cap_level == control_b[`TMR_CB_EDGE]);  // [RULE9]

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      filter_shift <= 4'h0;
      filter_level <= 1'b0;
      capture_prev <= 1'b0;
    end
    else
    begin
      filter_shift <= {filter_shift[2:0], cap_sync};
      if (&filter_shift || ~|filter_shift)
        filter_level <= filter_shift[3];  // [RULE9]
      capture_prev <= cap_level;
    end
  end

  // A CPU write wins over a capture in the same cycle.
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      capture_value <= `TMR_RST_WORD;
    else if (wr_cap_l)
      capture_value <= {high_hold, i_wdata};  // [RULE14]
    else if (cap_event && top_sel != TMR_TOP_CAP && !i_timer_power_off)
      capture_value <= counter_value;  // [RULE9]
  end

  // ----------------------------------------------------------------
  // Shared high byte, flags and plain control registers
  // ----------------------------------------------------------------
  // One holding byte serves all 16-bit registers; compare reads leave it alone.
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      high_hold <= `TMR_RST_BYTE;
    else if (wr_high)
      high_hold <= i_wdata;  // [RULE13]
    else if (rd_cnt_l)
      high_hold <= counter_value[15:8];  // [RULE15]
    else if (rd_cap_l)
      high_hold <= capture_value[15:8];
  end

  wire [7:0] flag_set = {2'b00, cap_event && !i_timer_power_off, 2'b00, match_b, match_a, overflow};
  wire [7:0] flag_clr = wr_flags ? i_wdata : 8'h00;

  // Set wins over a write-one clear landing in the same cycle.
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      irq_flags <= `TMR_RST_BYTE;
      irq_mask  <= `TMR_RST_BYTE;
      control_a <= `TMR_RST_BYTE;
      control_b <= `TMR_RST_BYTE;
    end
    else
    begin
      irq_flags <= (irq_flags & ~flag_clr) | flag_set;  // [RULE6]
      if (wr_mask)
        irq_mask <= i_wdata & 8'h27;
      if (wr_ca)
        control_a <= i_wdata;  // [RULE5]
      if (wr_cb)
        control_b <= i_wdata & 8'hDF;
    end
  end

  assign o_irq_req = {irq_flags[`TMR_FLG_CAP], irq_flags[2:0]} & {irq_mask[`TMR_FLG_CAP], irq_mask[2:0]};  // [RULE6]

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire [7:0] read_mux =
    (i_addr == `TMR_ADR_SYNC)   ? {sync_hold_mode, 5'b00000, async_prescaler_reset, sync_prescaler_reset} :
    (i_addr == `TMR_ADR_CTRL_A) ? control_a :
    (i_addr == `TMR_ADR_CTRL_B) ? control_b :
    (i_addr == `TMR_ADR_CNT_L)  ? counter_value[7:0] :
    (i_addr == `TMR_ADR_CMPA_L) ? compare_a_value[7:0] :
    (i_addr == `TMR_ADR_CMPA_H) ? compare_a_value[15:8] :  // [RULE16]
    (i_addr == `TMR_ADR_CMPB_L) ? compare_b_value[7:0] :
    (i_addr == `TMR_ADR_CMPB_H) ? compare_b_value[15:8] :
    (i_addr == `TMR_ADR_CAP_L)  ? capture_value[7:0] :
    (i_addr == `TMR_ADR_CNT_H || i_addr == `TMR_ADR_CAP_H) ? high_hold :
    (i_addr == `TMR_ADR_FLAGS)  ? irq_flags :
    (i_addr == `TMR_ADR_MASK)   ? irq_mask : 8'h00;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_rdata <= `TMR_RST_BYTE;
    else if (i_rd)
      o_rdata <= read_mux;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  sequence s_hold_set;
    wr_sync && i_wdata[`TMR_SYNC_HOLD] && i_wdata[`TMR_SYNC_SRST];
  endsequence

  sequence s_quiet_two;
    !wr_sync [*2];
  endsequence

  hold_keeps_reset_a: assert property (s_hold_set ##1 s_quiet_two |-> sync_prescaler_reset && prescaler == 10'h000) // [RULE1]
    else $error("held prescaler reset was lost");
  release_clears_a: assert property (wr_sync && !i_wdata[`TMR_SYNC_HOLD] ##1 !wr_sync |=> !sync_prescaler_reset) // [RULE2]
    else $error("prescaler reset not cleared after hold release");
  shared_reset_a: assert property (sync_prescaler_reset |=> prescaler == 10'h000) // [RULE3]
    else $error("prescaler not reset");
  self_clear_a: assert property (sync_prescaler_reset && !sync_hold_mode && !wr_sync |=> !sync_prescaler_reset) // [RULE4]
    else $error("sync reset did not self-clear");
  no_clock_a: assert property (clock_select == TMR_CS_OFF && !wr_cnt_l |=> $stable(counter_value)) // [RULE7]
    else $error("counter moved with no clock");
  match_flag_a: assert property (match_a && !wr_flags |=> irq_flags[`TMR_FLG_CMPA]) // [RULE8]
    else $error("compare A match did not set flag");
  low_write_a: assert property (wr_cnt_l |=> counter_value == {$past(high_hold), $past(i_wdata)}) // [RULE14]
    else $error("low byte write loaded wrong value");
  low_read_a: assert property (rd_cnt_l && !wr_high |=> high_hold == $past(counter_value[15:8])) // [RULE15]
    else $error("low byte read did not copy high byte");
  cmp_read_a: assert property (i_rd && !i_wr && i_addr == `TMR_ADR_CMPA_H |=> $stable(high_hold)) // [RULE16]
    else $error("compare read touched holding byte");
  power_off_a: assert property (i_timer_power_off && !wr_cnt_l |=> $stable(counter_value)) // [RULE18]
    else $error("counter moved while powered off");
  ext_rise_a: assert property (clock_select == TMR_CS_RISE && !i_timer_power_off |-> timer_tick == ext_rise) // [RULE19]
    else $error("external tick mismatch");
  tap_eight_a: assert property (clock_select == TMR_CS_DIV8 && timer_tick |=> !timer_tick [*7]) // [RULE20]
    else $error("divide by 8 tap too fast");

endmodule : tmr_timer16

// File: logic/tmr_defines.svh
// Register offsets, field positions, reset values and fixed counts of the 16-bit timer.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets on the 8-bit I/O bus
// ----------------------------------------------------------------
`define TMR_ADR_SYNC    8'h00
`define TMR_ADR_CTRL_A  8'h01
`define TMR_ADR_CTRL_B  8'h02
`define TMR_ADR_CNT_L   8'h04
`define TMR_ADR_CNT_H   8'h05
`define TMR_ADR_CMPA_L  8'h06
`define TMR_ADR_CMPA_H  8'h07
`define TMR_ADR_CMPB_L  8'h08
`define TMR_ADR_CMPB_H  8'h09
`define TMR_ADR_CAP_L   8'h0A
`define TMR_ADR_CAP_H   8'h0B
`define TMR_ADR_FLAGS   8'h0C
`define TMR_ADR_MASK    8'h0D

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TMR_SYNC_HOLD   7
`define TMR_SYNC_ARST   1
`define TMR_SYNC_SRST   0
`define TMR_FLG_OVF     0
`define TMR_FLG_CMPA    1
`define TMR_FLG_CMPB    2
`define TMR_FLG_CAP     5
`define TMR_CB_NOISE    7
`define TMR_CB_EDGE     6

// ----------------------------------------------------------------
// Reset values and fixed counts
// ----------------------------------------------------------------
`define TMR_RST_BYTE    8'h00
`define TMR_RST_WORD    16'h0000
`define TMR_BOTTOM      16'h0000
`define TMR_MAX         16'hFFFF
`define TMR_TOP_8BIT    16'h00FF
`define TMR_TOP_9BIT    16'h01FF
`define TMR_TOP_10BIT   16'h03FF
`define TMR_FLT_LEN     4

`endif

// File: logic/tmr_pkg.sv
// Types shared by the 16-bit timer files.
package tmr_pkg;

  typedef logic [15:0] tmr_word_t;  // One 16-bit timer register.

  // Source of the TOP value of the count sequence.
  typedef enum logic [2:0] {
    TMR_TOP_MAX   = 3'b000,
    TMR_TOP_FF    = 3'b001,
    TMR_TOP_1FF   = 3'b010,
    TMR_TOP_3FF   = 3'b011,
    TMR_TOP_CMPA  = 3'b100,
    TMR_TOP_CAP   = 3'b101
  } tmr_top_e;

  // Timer clock selection.
  typedef enum logic [2:0] {
    TMR_CS_OFF    = 3'b000,
    TMR_CS_DIV1   = 3'b001,
    TMR_CS_DIV8   = 3'b010,
    TMR_CS_DIV64  = 3'b011,
    TMR_CS_DIV256 = 3'b100,
    TMR_CS_DIV1K  = 3'b101,
    TMR_CS_FALL   = 3'b110,
    TMR_CS_RISE   = 3'b111
  } tmr_cs_e;

endpackage : tmr_pkg

// File: logic/tmr_edge_sync.sv
// Two-stage pin synchroniser with rising and falling edge pulses.
`timescale 1ns/1ps

module tmr_edge_sync
(
  input  wire logic i_clock,    // System clock.
  input  wire logic i_sys_rst,  // Asynchronous reset, active high.
  input  wire logic i_pin,      // Raw pin level from outside.
  output logic      o_level,    // Synchronised level.
  output logic      o_rise,     // One-cycle pulse on a rising edge.
  output logic      o_fall      // One-cycle pulse on a falling edge.
);

  logic stage1;  // First stage, read only by the second.
  logic stage2;  // Second stage, safe to use.
  logic stage3;  // Previous safe sample for the edge detector.

  // ----------------------------------------------------------------
  // Sampling chain
  // ----------------------------------------------------------------
  // The extra stage costs a cycle of latency but keeps the edge detector off a metastable flop.
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign o_level = stage2;
  assign o_rise  = stage2 & ~stage3;
  assign o_fall  = ~stage2 & stage3;

endmodule : tmr_edge_sync

// File: dv/tmr_cpu_model.sv
// CPU side model that issues single register reads and writes on the 8-bit bus.
`timescale 1ns/1ps

module tmr_cpu_model
(
  input  wire logic       i_clock, // System clock.
  output logic      [7:0] o_addr,  // Register offset.
  output logic            o_wr,    // Write strobe.
  output logic            o_rd,    // Read strobe.
  output logic      [7:0] o_wdata  // Write data.
);
  // Idle bus at time zero.
  initial {o_addr, o_wr, o_rd, o_wdata} = '0;

  // One strobe per access, held across exactly one sampling edge.
  // Callers keep high-before-low on writes and low-before-high on reads.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    #1 {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
    @(posedge i_clock);
    #1 {o_wr, o_rd} = 2'b00;
    o_wdata = ~o_wdata; // Released data must not look valid.
  endtask : acc
endmodule : tmr_cpu_model

// File: dv/test_timer16_sync_and_byte_access.sv
// Self-checking bench for timer register access, prescaler sync control and counting.
`timescale 1ns/1ps
`include "tmr_defines.svh"
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, s); end end

module test_timer16_sync_and_byte_access;
  logic       i_clock = 0, i_sys_rst = 1, pwr_off = 0, ext_pin = 0; // Clock, reset, pins.
  logic [7:0] addr, wdata, rdata;                                     // Register bus.
  logic       wr, rd, out_a, out_b;                                   // Strobes and outputs.
  logic [3:0] irq;                                                    // Interrupt requests.
  int         bad_count = 0, num_checks = 0, seed = 21564, n;         // Counters and seed.
  logic [7:0] exp_q[$];                                               // Expected read data.
  logic [7:0] exp_b;                                                  // Oldest note, popped once.
  logic       cap_pin = 0;                                            // Capture pin.

  always #2.5 i_clock = ~i_clock; // 200 MHz.

  tmr_cpu_model tmr_cpu_model_i (.i_clock(i_clock), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  tmr_timer16 tmr_timer16_i (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(addr), .i_wr(wr), .i_rd(rd),
    .i_wdata(wdata), .o_rdata(rdata), .i_timer_power_off(pwr_off), .i_capture_from_cmp(1'b0),
    .i_external_count_pin(ext_pin), .i_capture_pin(cap_pin), .i_analog_cmp(1'b0),
    .o_compare_a_output(out_a), .o_compare_b_output(out_b), .o_irq_req(irq));

  // Read data settles one edge after the strobe; the oldest note is compared then.
  always @(posedge i_clock)
    if (rd === 1'b1)
    begin
      @(negedge i_clock);
      exp_b = exp_q.pop_front();
      `CHK("rdata", exp_b, rdata)
    end

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    tmr_cpu_model_i.acc(1'b1, a, d);
  endtask : wr8

  // Notes the expected byte, then reads.
  task automatic rdx(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    tmr_cpu_model_i.acc(1'b0, a, 8'h00);
  endtask : rdx

  // Slow pulses on the count pin, each half period well above one clock.
  task automatic pulses(input int k);
    repeat (k)
    begin
      repeat (3) @(posedge i_clock);
      #1 ext_pin = 1;
      repeat (3) @(posedge i_clock);
      #1 ext_pin = 0;
    end
    repeat (6) @(posedge i_clock);
  endtask : pulses

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Watchdog well beyond the expected few hundred cycles.
  initial
  begin
    #100us;
    bad_count++;
    final_report();
  end

  initial
  begin
    repeat (3) @(posedge i_clock);
    #1 i_sys_rst = 0;
    rdx(`TMR_ADR_SYNC, 8'h00);
    wr8(`TMR_ADR_CNT_H, 8'h01);
    wr8(`TMR_ADR_CNT_L, 8'hFF);
    wr8(`TMR_ADR_CMPA_H, 8'h12);
    wr8(`TMR_ADR_CMPA_L, 8'h34);
    rdx(`TMR_ADR_CNT_L, 8'hFF);
    rdx(`TMR_ADR_CMPA_L, 8'h34);
    rdx(`TMR_ADR_CMPA_H, 8'h12);
    rdx(`TMR_ADR_CNT_H, 8'h01);
    wr8(`TMR_ADR_SYNC, 8'h83);
    rdx(`TMR_ADR_SYNC, 8'h83);
    wr8(`TMR_ADR_SYNC, 8'h00);
    rdx(`TMR_ADR_SYNC, 8'h00);
    wr8(`TMR_ADR_SYNC, 8'h01);
    repeat (2) @(posedge i_clock);
    rdx(`TMR_ADR_SYNC, 8'h00);
    // Held prescaler keeps a divide-by-8 count at zero, then four ticks in 36 cycles.
    wr8(`TMR_ADR_SYNC, 8'h81);
    wr8(`TMR_ADR_CTRL_B, 8'h02);
    wr8(`TMR_ADR_CNT_H, 8'h00);
    wr8(`TMR_ADR_CNT_L, 8'h00);
    repeat (40) @(posedge i_clock);
    rdx(`TMR_ADR_CNT_L, 8'h00);
    wr8(`TMR_ADR_SYNC, 8'h00);
    repeat (36) @(posedge i_clock);
    rdx(`TMR_ADR_CNT_L, 8'h04);
    // External edges: rising, then falling, then ignored while powered off.
    wr8(`TMR_ADR_CTRL_B, 8'h07);
    wr8(`TMR_ADR_CNT_L, 8'h00);
    n = 1 + ($random(seed) & 7);
    pulses(n);
    rdx(`TMR_ADR_CNT_L, n[7:0]);
    wr8(`TMR_ADR_CTRL_B, 8'h06);
    pulses(n);
    rdx(`TMR_ADR_CNT_L, 8'(2 * n));
    pwr_off = 1;
    pulses(3);
    rdx(`TMR_ADR_CNT_L, 8'(2 * n));
    pwr_off = 0;
    // Wrap from MAX through BOTTOM and pass compare A, with compare B out of reach.
    wr8(`TMR_ADR_CMPA_L, 8'h03);
    wr8(`TMR_ADR_CMPB_L, 8'h80);
    wr8(`TMR_ADR_CNT_H, 8'hFF);
    wr8(`TMR_ADR_CNT_L, 8'hFF);
    wr8(`TMR_ADR_CTRL_B, 8'h07);
    // Compare B at its reset value of zero matched when the early counts left zero.
    rdx(`TMR_ADR_FLAGS, 8'h04);
    wr8(`TMR_ADR_FLAGS, 8'h27);
    wr8(`TMR_ADR_CTRL_A, 8'h70);
    pulses(5);
    rdx(`TMR_ADR_FLAGS, 8'h03);
    `CHK("out_a", 1'b1, out_a)
    `CHK("out_b", 1'b0, out_b)
    `CHK("irq", 4'b0000, irq)
    wr8(`TMR_ADR_MASK, 8'h02);
    `CHK("irq", 4'b0010, irq)
    wr8(`TMR_ADR_FLAGS, 8'h03);
    rdx(`TMR_ADR_FLAGS, 8'h00);
    `CHK("irq", 4'b0000, irq)
    // A rising capture edge latches the idle count of 4.
    wr8(`TMR_ADR_CTRL_B, 8'h47);
    cap_pin = 1;
    repeat (4) @(posedge i_clock);
    rdx(`TMR_ADR_CAP_L, 8'h04);
    rdx(`TMR_ADR_FLAGS, 8'h20);
    repeat (3) @(posedge i_clock);
    final_report();
  end
endmodule : test_timer16_sync_and_byte_access
